//--- src/cohb_pkg.sv
// constants, types and helper functions of the heartbeat and network-state node
package cohb_pkg;

  // ----------------------------------------------------------------
  // identifiers and frame layout
  // ----------------------------------------------------------------
  localparam logic [10:0] ID_NMT = 11'h000; // command frames
  localparam logic [10:0] ID_PDO_BASE = 11'h180; // first process-data frame
  localparam logic [10:0] ID_SDO_RSP_BASE = 11'h580; // download responses
  localparam logic [10:0] ID_SDO_REQ_BASE = 11'h600; // download requests
  localparam logic [10:0] ID_HB_BASE = 11'h700; // heartbeat and boot-up
  localparam logic [3:0] DLC_NMT = 4'h2;
  localparam logic [3:0] DLC_HB = 4'h1;
  localparam logic [3:0] DLC_SDO = 4'h8;
  localparam logic [3:0] DLC_PDO = 4'h5; // default process-data length

  // ----------------------------------------------------------------
  // command codes and status bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_START = 8'h01;
  localparam logic [7:0] CMD_STOP = 8'h02;
  localparam logic [7:0] CMD_PREOP = 8'h80;
  localparam logic [7:0] CMD_RST_NODE = 8'h81;
  localparam logic [7:0] CMD_RST_COMM = 8'h82;
  localparam logic [6:0] NODE_ALL = 7'h00; // broadcast target
  localparam logic [7:0] STAT_BOOT = 8'h00;
  localparam logic [7:0] STAT_STOP = 8'h04;
  localparam logic [7:0] STAT_OP = 8'h05;
  localparam logic [7:0] STAT_PREOP = 8'h7f;
  localparam logic [7:0] SDO_RSP_OK = 8'h60; // download confirmed

  // ----------------------------------------------------------------
  // defaults and timing
  // ----------------------------------------------------------------
  localparam logic [6:0] NODE_ID_DEF = 7'h01;
  localparam logic [15:0] HB_TIME_DEF = 16'd1000; // ms
  localparam logic [15:0] PDO_TIMER_MS = 16'd1000; // event timer, transmission type 254
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned CYC_PER_MS = MS_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_INIT = 4'b0001,
    ST_PREOP = 4'b0010,
    ST_OP = 4'b0100,
    ST_STOP = 4'b1000
  } cohb_state_t;

  typedef struct packed {
    logic [10:0] id;
    logic [3:0] dlc;
    logic [63:0] data; // byte 0 in bits 7:0
  } cohb_frame_t;

  typedef struct packed {
    logic valid; // one-cycle pulse
    logic [15:0] index;
    logic [7:0] sub;
    logic [31:0] data;
  } cohb_sdo_wr_t;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // identifier of a per-node service
  function automatic logic [10:0] node_cob(input logic [10:0] base, input logic [6:0] node);
    return base + {4'h0, node};
  endfunction

  // heartbeat status byte of a state
  function automatic logic [7:0] stat_of(input cohb_state_t st);
    unique case (st)
      ST_STOP: return STAT_STOP;
      ST_OP: return STAT_OP;
      ST_PREOP: return STAT_PREOP;
      default: return STAT_BOOT;
    endcase
  endfunction

endpackage

//--- src/cohb_ms_timer.sv
// millisecond period timer giving a one-cycle tick every period
module cohb_ms_timer #(
  parameter int unsigned CYC_PER_MS = cohb_pkg::CYC_PER_MS
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // control
  input wire logic run, // low restarts the period
  input wire logic [15:0] period_ms, // zero never ticks
  // result
  output logic tick_ff
);

  logic [31:0] pre_ff; // cycles within one ms
  logic [31:0] nxt_pre;
  logic [15:0] ms_ff; // ms within one period
  logic [15:0] nxt_ms;
  logic nxt_tick;

  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------
  always_comb begin
    nxt_pre = pre_ff;
    nxt_ms = ms_ff;
    nxt_tick = 1'b0;
    if (!run || period_ms == 16'h0000) begin
      // stopped timer keeps no partial period
      nxt_pre = 32'h0;
      nxt_ms = 16'h0000;
    end else if (pre_ff >= CYC_PER_MS - 1) begin
      nxt_pre = 32'h0;
      if (ms_ff >= period_ms - 16'h0001) begin
        nxt_ms = 16'h0000;
        nxt_tick = 1'b1;
      end else begin
        nxt_ms = ms_ff + 16'h0001;
      end
    end else begin
      nxt_pre = pre_ff + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pre_ff <= 32'h0;
      ms_ff <= 16'h0000;
      tick_ff <= 1'b0;
    end else begin
      pre_ff <= nxt_pre;
      ms_ff <= nxt_ms;
      tick_ff <= nxt_tick;
    end
  end

endmodule // cohb_ms_timer

//--- src/cohb_node.sv
// network-state handling, boot-up and heartbeat producer of one node
module cohb_node #(
  parameter int unsigned CYC_PER_MS = cohb_pkg::CYC_PER_MS, // shorten in simulation
  parameter logic [15:0] PDO_TIMER_MS = cohb_pkg::PDO_TIMER_MS,
  parameter logic [3:0] PDO_DLC = cohb_pkg::DLC_PDO
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // configuration and start-up
  input wire logic [6:0] node_id,
  input wire logic [15:0] hb_time_ms,
  input wire logic init_done,
  // received frames from the controller
  input wire logic rx_valid,
  input wire cohb_pkg::cohb_frame_t rx_frame,
  // frames to the controller
  output logic tx_valid_ff,
  output cohb_pkg::cohb_frame_t tx_frame_ff,
  input wire logic tx_ready,
  // application side
  input wire logic [63:0] pdo_data,
  output cohb_pkg::cohb_sdo_wr_t sdo_wr_ff,
  output logic [7:0] nmt_status_ff
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  cohb_pkg::cohb_state_t state_ff; // network state
  cohb_pkg::cohb_state_t nxt_state;
  logic boot_done_ff; // boot-up frame handed over
  logic nxt_boot_done;
  logic boot_pend_ff; // boot-up waits for the controller
  logic nxt_boot_pend;
  logic hb_pend_ff;
  logic nxt_hb_pend;
  logic pdo_pend_ff;
  logic nxt_pdo_pend;
  logic sdo_pend_ff;
  logic nxt_sdo_pend;
  logic [23:0] sdo_mux_ff; // index and sub of the pending answer
  logic [23:0] nxt_sdo_mux;
  logic nxt_tx_valid;
  cohb_pkg::cohb_frame_t nxt_tx_frame;
  cohb_pkg::cohb_sdo_wr_t nxt_sdo_wr;
  logic [7:0] nxt_status;
  logic hb_tick; // period elapsed
  logic pdo_tick;
  logic hb_run;
  logic pdo_run;
  logic nmt_hit; // command frame addressed to us
  logic sdo_hit; // expedited download to us
  logic [7:0] nmt_cmd;
  logic [6:0] nmt_node;
  logic [7:0] sdo_cs;

  // ----------------------------------------------------------------
  // period timers
  // ----------------------------------------------------------------
  // heartbeat starts only after boot-up so the boot frame is first
  assign hb_run = boot_done_ff;
  assign pdo_run = (state_ff == cohb_pkg::ST_OP);

  cohb_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_hb_timer (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .run(hb_run),
    .period_ms(hb_time_ms),
    .tick_ff(hb_tick)
  );

  cohb_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_pdo_timer (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .run(pdo_run),
    .period_ms(PDO_TIMER_MS),
    .tick_ff(pdo_tick)
  );

  // ----------------------------------------------------------------
  // receive decode
  // ----------------------------------------------------------------
  assign nmt_cmd = rx_frame.data[7:0];
  assign nmt_node = rx_frame.data[14:8];
  // a target byte above 127 never matches, so it is ignored too
  assign nmt_hit = rx_valid && rx_frame.id == cohb_pkg::ID_NMT
    && rx_frame.dlc == cohb_pkg::DLC_NMT && !rx_frame.data[15]
    && (nmt_node == cohb_pkg::NODE_ALL || nmt_node == node_id);
  assign sdo_cs = rx_frame.data[7:0];
  // expedited download with size indicated: command specifier 1, e and s set
  assign sdo_hit = rx_valid && rx_frame.dlc == cohb_pkg::DLC_SDO
    && rx_frame.id == cohb_pkg::node_cob(cohb_pkg::ID_SDO_REQ_BASE, node_id)
    && sdo_cs[7:5] == 3'b001 && sdo_cs[1:0] == 2'b11;

  // ----------------------------------------------------------------
  // next state, pending frames and transmit
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_boot_done = boot_done_ff;
    nxt_boot_pend = boot_pend_ff;
    nxt_hb_pend = hb_pend_ff;
    nxt_pdo_pend = pdo_pend_ff;
    nxt_sdo_pend = sdo_pend_ff;
    nxt_sdo_mux = sdo_mux_ff;
    nxt_tx_valid = tx_valid_ff;
    nxt_tx_frame = tx_frame_ff;
    nxt_sdo_wr = '0;
    // network state
    unique case (state_ff)
      cohb_pkg::ST_INIT: begin
        if (init_done) begin
          nxt_state = cohb_pkg::ST_PREOP;
          nxt_boot_pend = 1'b1;
        end
      end
      cohb_pkg::ST_PREOP, cohb_pkg::ST_OP, cohb_pkg::ST_STOP: begin
        if (nmt_hit) begin
          unique case (nmt_cmd)
            cohb_pkg::CMD_START: nxt_state = cohb_pkg::ST_OP;
            cohb_pkg::CMD_STOP: nxt_state = cohb_pkg::ST_STOP;
            cohb_pkg::CMD_PREOP: nxt_state = cohb_pkg::ST_PREOP;
            cohb_pkg::CMD_RST_NODE, cohb_pkg::CMD_RST_COMM: begin
              // restart: boot-up is sent again and the pending heartbeat is cleared
              nxt_state = cohb_pkg::ST_INIT;
              nxt_boot_done = 1'b0;
              nxt_hb_pend = 1'b0;
            end
            default: ; // unknown commands are ignored
          endcase
        end
      end
      default: nxt_state = cohb_pkg::ST_INIT;
    endcase
    // downloads only in pre-operational and operational
    if (sdo_hit && (state_ff == cohb_pkg::ST_PREOP || state_ff == cohb_pkg::ST_OP)) begin
      nxt_sdo_pend = 1'b1;
      nxt_sdo_mux = rx_frame.data[31:8];
      nxt_sdo_wr.valid = 1'b1;
      nxt_sdo_wr.index = rx_frame.data[23:8];
      nxt_sdo_wr.sub = rx_frame.data[31:24];
      nxt_sdo_wr.data = rx_frame.data[63:32];
    end
    // controller took the frame
    if (tx_valid_ff && tx_ready) begin
      nxt_tx_valid = 1'b0;
    end
    // load the next frame, boot-up first, then by bus priority
    if (!tx_valid_ff) begin
      if (boot_pend_ff) begin
        nxt_boot_pend = 1'b0;
        nxt_boot_done = 1'b1;
        nxt_tx_valid = 1'b1;
        nxt_tx_frame.id = cohb_pkg::node_cob(cohb_pkg::ID_HB_BASE, node_id);
        nxt_tx_frame.dlc = cohb_pkg::DLC_HB;
        nxt_tx_frame.data = {56'h0, cohb_pkg::STAT_BOOT};
      end else if (pdo_pend_ff) begin
        nxt_pdo_pend = 1'b0;
        nxt_tx_valid = 1'b1;
        nxt_tx_frame.id = cohb_pkg::node_cob(cohb_pkg::ID_PDO_BASE, node_id);
        nxt_tx_frame.dlc = PDO_DLC;
        nxt_tx_frame.data = pdo_data;
      end else if (sdo_pend_ff) begin
        nxt_sdo_pend = 1'b0;
        nxt_tx_valid = 1'b1;
        nxt_tx_frame.id = cohb_pkg::node_cob(cohb_pkg::ID_SDO_RSP_BASE, node_id);
        nxt_tx_frame.dlc = cohb_pkg::DLC_SDO;
        nxt_tx_frame.data = {32'h0, sdo_mux_ff, cohb_pkg::SDO_RSP_OK};
      end else if (hb_pend_ff) begin
        nxt_hb_pend = 1'b0;
        nxt_tx_valid = 1'b1;
        nxt_tx_frame.id = cohb_pkg::node_cob(cohb_pkg::ID_HB_BASE, node_id);
        nxt_tx_frame.dlc = cohb_pkg::DLC_HB;
        nxt_tx_frame.data = {56'h0, cohb_pkg::stat_of(state_ff)};
      end
    end
    // events set after the clears above, so a tick is never lost
    if (hb_tick && boot_done_ff) begin
      nxt_hb_pend = 1'b1;
    end
    if (pdo_tick && state_ff == cohb_pkg::ST_OP) begin
      nxt_pdo_pend = 1'b1;
    end
    // a process-data frame not yet loaded dies with operational
    if (nxt_state != cohb_pkg::ST_OP) begin
      nxt_pdo_pend = 1'b0;
    end
    // an answer not yet loaded is dropped on stop
    if (nxt_state == cohb_pkg::ST_STOP || nxt_state == cohb_pkg::ST_INIT) begin
      nxt_sdo_pend = 1'b0;
    end
  end

  // status byte for the application follows the next state
  always_comb begin
    nxt_status = cohb_pkg::stat_of(nxt_state);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_ff <= cohb_pkg::ST_INIT;
      boot_done_ff <= 1'b0;
      boot_pend_ff <= 1'b0;
      hb_pend_ff <= 1'b0;
      pdo_pend_ff <= 1'b0;
      sdo_pend_ff <= 1'b0;
      sdo_mux_ff <= 24'h0;
      tx_valid_ff <= 1'b0;
      tx_frame_ff <= '0;
      sdo_wr_ff <= '0;
      nmt_status_ff <= cohb_pkg::STAT_BOOT;
    end else begin
      state_ff <= nxt_state;
      boot_done_ff <= nxt_boot_done;
      boot_pend_ff <= nxt_boot_pend;
      hb_pend_ff <= nxt_hb_pend;
      pdo_pend_ff <= nxt_pdo_pend;
      sdo_pend_ff <= nxt_sdo_pend;
      sdo_mux_ff <= nxt_sdo_mux;
      tx_valid_ff <= nxt_tx_valid;
      tx_frame_ff <= nxt_tx_frame;
      sdo_wr_ff <= nxt_sdo_wr;
      nmt_status_ff <= nxt_status;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  logic hb_id_out; // frame on the heartbeat identifier
  logic tx_new; // frame loaded last cycle
  logic tx_seen_ff; // offer flag one cycle back, for edge detection
  assign hb_id_out = tx_frame_ff.id == cohb_pkg::node_cob(cohb_pkg::ID_HB_BASE, node_id);
  assign tx_new = tx_valid_ff && !tx_seen_ff;

  // delayed copy of the offer flag; reset low matches the idle level
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tx_seen_ff <= 1'b0;
    end else begin
      tx_seen_ff <= tx_valid_ff;
    end
  end

  AST_HB_LEN: assert property (tx_valid_ff && hb_id_out |-> tx_frame_ff.dlc == 4'h1)
    else $error("heartbeat length not one");
  AST_BOOT_ZERO: assert property (tx_new && hb_id_out && !$past(boot_done_ff)
    |-> tx_frame_ff.data[7:0] == 8'h00 && boot_done_ff)
    else $error("boot-up frame not first or status not zero");
  AST_HB_STATUS: assert property (tx_new && hb_id_out && $past(boot_done_ff)
    |-> tx_frame_ff.data[7:0] == cohb_pkg::stat_of($past(state_ff)))
    else $error("heartbeat status does not match state");
  AST_HB_OFF: assert property (hb_time_ms == 16'h0000 && tx_new && hb_id_out
    && $past(hb_time_ms) == 16'h0000 && $past(hb_time_ms, 2) == 16'h0000
    |-> !$past(boot_done_ff))
    else $error("heartbeat sent with period zero");
  AST_START: assert property (nmt_hit && nmt_cmd == 8'h01 && state_ff != cohb_pkg::ST_INIT
    |=> state_ff == cohb_pkg::ST_OP ##1 nmt_status_ff == 8'h05)
    else $error("start command did not reach operational");
  AST_PREOP: assert property (nmt_hit && nmt_cmd == 8'h80 && state_ff != cohb_pkg::ST_INIT
    |=> state_ff == cohb_pkg::ST_PREOP && !pdo_pend_ff)
    else $error("pre-operational command not obeyed");
  AST_PDO_OP: assert property (tx_new && tx_frame_ff.id
    == cohb_pkg::node_cob(cohb_pkg::ID_PDO_BASE, node_id) |-> $past(state_ff) == cohb_pkg::ST_OP)
    else $error("process data outside operational");
  AST_SDO_ANS: assert property (sdo_hit && state_ff == cohb_pkg::ST_PREOP && !tx_valid_ff
    && !boot_pend_ff && !pdo_pend_ff |=> ##[1:3] tx_valid_ff && tx_frame_ff.data[7:0] == 8'h60)
    else $error("download in pre-operational not answered");
  AST_SDO_STOP: assert property (tx_new && tx_frame_ff.id
    == cohb_pkg::node_cob(cohb_pkg::ID_SDO_RSP_BASE, node_id)
    |-> $past(state_ff) != cohb_pkg::ST_STOP)
    else $error("download answered while stopped");
  AST_FOREIGN: assert property (rx_valid && rx_frame.id == 11'h000 && rx_frame.data[14:8] != 7'h00
    && rx_frame.data[14:8] != node_id |=> $stable(state_ff))
    else $error("command for another node changed state");
  AST_TX_HOLD: assert property (tx_valid_ff && !tx_ready |=> tx_valid_ff && $stable(tx_frame_ff))
    else $error("frame changed before it was taken");

endmodule // cohb_node

//--- testbench/cohb_mgr_model.sv
// manager-side model: sends commands and requests, takes frames, watches heartbeat
module cohb_mgr_model #(
  parameter int unsigned HB_LIMIT = 100 // silent cycles before loss is flagged
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // frames from the node
  input wire logic tx_valid_ff,
  input wire cohb_pkg::cohb_frame_t tx_frame_ff,
  output logic tx_ready,
  // frames to the node
  output logic rx_valid,
  output cohb_pkg::cohb_frame_t rx_frame,
  // control and status
  input wire logic slow,
  input wire logic [10:0] hb_id,
  output logic hb_lost
);
  timeunit 1ns;
  timeprecision 1ps;

  cohb_pkg::cohb_frame_t got_q[$]; // taken frames, oldest first
  int got_t[$]; // cycle stamp of each taken frame
  int cyc = 0; // free-running cycle count
  int quiet = 0; // cycles since the last heartbeat
  logic [1:0] pace = 2'h0; // divider for slow acceptance

  initial begin
    tx_ready = 1'b1;
    rx_valid = 1'b0;
    rx_frame = '0;
    hb_lost = 1'b0;
  end

  // acceptance: slow mode takes at most one frame in four cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    pace <= pace + 2'h1;
    tx_ready <= !slow || (pace == 2'h3);
    if (tx_valid_ff && tx_ready) begin
      got_q.push_back(tx_frame_ff);
      got_t.push_back(cyc);
    end
  end

  // heartbeat consumer: a long silence is reported to the application
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      quiet <= 0;
      hb_lost <= 1'b0;
    end else if (tx_valid_ff && tx_ready && tx_frame_ff.id == hb_id) begin
      quiet <= 0;
      hb_lost <= 1'b0;
    end else begin
      quiet <= quiet + 1;
      if (quiet == HB_LIMIT) hb_lost <= 1'b1;
    end
  end

  // one frame to the node; released lines carry the inverse, not the old value
  task automatic send(input logic [10:0] id, input logic [3:0] dlc, input logic [63:0] data);
    @(posedge clk_sys);
    rx_valid <= 1'b1;
    rx_frame <= '{id: id, dlc: dlc, data: data};
    @(posedge clk_sys);
    rx_valid <= 1'b0;
    rx_frame <= ~rx_frame;
  endtask

  // state command: command code first, then target node
  task automatic nmt(input logic [7:0] cmd, input logic [6:0] node);
    send(cohb_pkg::ID_NMT, cohb_pkg::DLC_NMT, {48'h0, 1'b0, node, cmd});
  endtask
endmodule // cohb_mgr_model

//--- testbench/canopen_heartbeat_nmt_node_tb.sv
// self-checking bench of the node: boot, heartbeat, state commands, downloads
module canopen_heartbeat_nmt_node_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // settings, shortened so a run stays brief
  // ----------------------------------------------------------------
  localparam int unsigned CYC = 10; // cycles per millisecond
  localparam logic [15:0] HB_MS = 16'h0003;
  localparam logic [15:0] PD_MS = 16'h0004;
  localparam int HB_CYC = 30; // CYC * HB_MS
  localparam int PD_CYC = 40; // CYC * PD_MS
  localparam logic [6:0] NODE = 7'h0b; // non-trivial so the sum shows
  localparam logic [10:0] HB_ID = cohb_pkg::ID_HB_BASE + {4'h0, NODE};
  localparam logic [10:0] PD_ID = cohb_pkg::ID_PDO_BASE + {4'h0, NODE};
  localparam logic [10:0] RQ_ID = cohb_pkg::ID_SDO_REQ_BASE + {4'h0, NODE};
  localparam logic [10:0] RS_ID = cohb_pkg::ID_SDO_RSP_BASE + {4'h0, NODE};
  localparam logic [63:0] PD_VAL = 64'h0000_0000_0044_0053;
  localparam logic [63:0] RQ_VAL = 64'h0000_0001_0053_002f; // write 5300.0 = 1

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [6:0] node_id = NODE;
  logic [15:0] hb_time_ms = HB_MS;
  logic init_done = 1'b0;
  logic [63:0] pdo_data = PD_VAL;
  logic slow = 1'b0; // far side stalls when high
  logic rx_valid;
  logic tx_valid_ff;
  logic tx_ready;
  logic hb_lost;
  logic [7:0] nmt_status_ff;
  cohb_pkg::cohb_frame_t rx_frame;
  cohb_pkg::cohb_frame_t tx_frame_ff;
  cohb_pkg::cohb_sdo_wr_t sdo_wr_ff;
  int bad_count = 0;
  int cmp_count = 0;
  int wr_count = 0; // download pulses seen
  cohb_pkg::cohb_frame_t f;
  int t1;
  int t2;

  always #2.5 clk_sys = ~clk_sys;

  cohb_node #(.CYC_PER_MS(CYC), .PDO_TIMER_MS(PD_MS)) dut_u (
    .clk_sys(clk_sys), .nrst(nrst), .node_id(node_id), .hb_time_ms(hb_time_ms),
    .init_done(init_done), .rx_valid(rx_valid), .rx_frame(rx_frame),
    .tx_valid_ff(tx_valid_ff), .tx_frame_ff(tx_frame_ff), .tx_ready(tx_ready),
    .pdo_data(pdo_data), .sdo_wr_ff(sdo_wr_ff), .nmt_status_ff(nmt_status_ff)
  );

  cohb_mgr_model mgr_u (
    .clk_sys(clk_sys), .nrst(nrst), .tx_valid_ff(tx_valid_ff), .tx_frame_ff(tx_frame_ff),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_frame(rx_frame), .slow(slow),
    .hb_id(HB_ID), .hb_lost(hb_lost)
  );

  // count download pulses; a pulse is one cycle so every edge is looked at
  always @(posedge clk_sys) begin
    if (sdo_wr_ff.valid === 1'b1) wr_count++;
  end

  // ----------------------------------------------------------------
  // compare and helper tasks
  // ----------------------------------------------------------------
  // bytes beyond the length code are not part of the frame, so masked
  task automatic cmp_frame(input cohb_pkg::cohb_frame_t got, input cohb_pkg::cohb_frame_t exp);
    logic [63:0] m;
    m = (exp.dlc >= 4'h8) ? '1 : ((64'h1 << (8 * exp.dlc)) - 64'h1);
    cmp_count++;
    if ({got.id, got.dlc, got.data & m} !== {exp.id, exp.dlc, exp.data & m}) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_stat(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_num(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic cohb_pkg::cohb_frame_t hbf(input logic [7:0] s);
    return '{id: HB_ID, dlc: cohb_pkg::DLC_HB, data: {56'h0, s}};
  endfunction

  task automatic flush();
    mgr_u.got_q.delete();
    mgr_u.got_t.delete();
  endtask

  // next taken frame with this identifier, others skipped; bounded wait
  task automatic wait_frame(input logic [10:0] id, output cohb_pkg::cohb_frame_t fr,
                            output int t);
    int n;
    n = 0;
    fr = '0;
    t = -1;
    while (t < 0 && n < 500) begin
      if (mgr_u.got_q.size() > 0) begin
        fr = mgr_u.got_q.pop_front();
        t = mgr_u.got_t.pop_front();
        if (fr.id !== id) t = -1;
      end else begin
        @(posedge clk_sys);
        #1;
        n++;
      end
    end
    if (t < 0) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, fr.id, id);
    end
  endtask

  // count frames of one identifier over a span; the caller expects none
  task automatic count_id(input logic [10:0] id, input int n, output int hits);
    hits = 0;
    flush();
    repeat (n) @(posedge clk_sys);
    #1;
    foreach (mgr_u.got_q[i]) if (mgr_u.got_q[i].id === id) hits++;
  endtask

  // status settles on the edge that samples the command; two more edges are waited
  task automatic cmd_and_wait(input logic [7:0] cmd, input logic [6:0] node);
    mgr_u.nmt(cmd, node);
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  task automatic do_reset(input logic [15:0] hb);
    nrst <= 1'b0;
    init_done <= 1'b0;
    hb_time_ms <= hb;
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    flush();
    init_done <= 1'b1;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_boot();
    wait_frame(HB_ID, f, t1);
    cmp_frame(f, hbf(cohb_pkg::STAT_BOOT));
    cmp_stat(nmt_status_ff, cohb_pkg::STAT_PREOP);
    wait_frame(HB_ID, f, t1);
    cmp_frame(f, hbf(cohb_pkg::STAT_PREOP));
    wait_frame(HB_ID, f, t2);
    cmp_num(t2 - t1, HB_CYC);
    $display("test boot and heartbeat done");
  endtask

  task automatic t_start();
    cmd_and_wait(cohb_pkg::CMD_START, cohb_pkg::NODE_ALL);
    cmp_stat(nmt_status_ff, cohb_pkg::STAT_OP);
    wait_frame(PD_ID, f, t1);
    cmp_frame(f, '{id: PD_ID, dlc: cohb_pkg::DLC_PDO, data: PD_VAL});
    wait_frame(PD_ID, f, t2);
    cmp_num((t2 - t1 >= PD_CYC) && (t2 - t1 <= PD_CYC + 3), 1);
    wait_frame(HB_ID, f, t1);
    cmp_frame(f, hbf(cohb_pkg::STAT_OP));
    cmd_and_wait(cohb_pkg::CMD_STOP, 7'h22);
    cmp_stat(nmt_status_ff, cohb_pkg::STAT_OP);
    $display("test start and foreign command done");
  endtask

  task automatic t_preop();
    cmd_and_wait(cohb_pkg::CMD_PREOP, NODE);
    cmp_stat(nmt_status_ff, cohb_pkg::STAT_PREOP);
    count_id(PD_ID, 2 * PD_CYC + 5, t1);
    cmp_num(t1, 0);
    wait_frame(HB_ID, f, t1);
    cmp_frame(f, hbf(cohb_pkg::STAT_PREOP));
    t2 = wr_count;
    mgr_u.send(RQ_ID, cohb_pkg::DLC_SDO, RQ_VAL);
    wait_frame(RS_ID, f, t1);
    cmp_frame(f, '{id: RS_ID, dlc: cohb_pkg::DLC_SDO, data: 64'h0000_0000_0053_0060});
    cmp_num(wr_count - t2, 1);
    $display("test pre-operational and download done");
  endtask

  task automatic t_stop();
    slow <= 1'b1;
    cmd_and_wait(cohb_pkg::CMD_STOP, NODE);
    cmp_stat(nmt_status_ff, cohb_pkg::STAT_STOP);
    t2 = wr_count;
    mgr_u.send(RQ_ID, cohb_pkg::DLC_SDO, RQ_VAL);
    count_id(RS_ID, 60, t1);
    cmp_num(t1, 0);
    cmp_num(wr_count - t2, 0);
    wait_frame(HB_ID, f, t1);
    cmp_frame(f, hbf(cohb_pkg::STAT_STOP));
    wait_frame(HB_ID, f, t1);
    cmp_frame(f, hbf(cohb_pkg::STAT_STOP));
    slow <= 1'b0;
    $display("test stopped done");
  endtask

  task automatic t_hb_off();
    do_reset(16'h0000);
    wait_frame(HB_ID, f, t1);
    cmp_frame(f, hbf(cohb_pkg::STAT_BOOT));
    count_id(HB_ID, 3 * HB_CYC, t1);
    cmp_num(t1, 0);
    $display("test heartbeat disabled done");
  endtask

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    do_reset(HB_MS);
    t_boot();
    t_start();
    t_preop();
    t_stop();
    t_hb_off();
    wrap_up();
  end

  // the whole run needs well under two thousand cycles
  initial begin
    #50000;
    bad_count++;
    wrap_up();
  end
endmodule // canopen_heartbeat_nmt_node_tb
